// ==== src/vc_resource_pkg.sv ====
// Notes on behaviour
// - table write sets table-status flag bit 16
// - table load completion clears table-status flag
// - negotiation-pending flag follows negotiation, resets zero
// - arbitration capability 19h with strap, else 00h
// - max time slots 7Fh with strap, else 0
// - table offset 08h sixteen-byte units with strap
// - capability reports round-robin and weighted schemes
// - advanced-switching-only bit 14 reads zero
// - class map bit 0 fixed zero, resets 00h
// - autoloaded class map replaces default after reset
// - load-table bit 16 triggers load, reads zero
// - arbitration select accepts 000/011/100, else 000
// - channel identifier resets 001b with strap
// - channel enable bit 31, resets zero
package vc_resource_pkg;
	// register byte addresses
	localparam logic [11:0] STATUS0_ADDR  = 12'h158;
	localparam logic [11:0] CAP1_ADDR     = 12'h15C;
	localparam logic [11:0] CTRL1_ADDR    = 12'h160;
	localparam logic [11:0] IRQ_STAT_ADDR = 12'h1F0;
	localparam logic [11:0] IRQ_MASK_ADDR = 12'h1F4;
	// field positions
	localparam int TBL_STATUS_BIT = 16;
	localparam int NEG_PEND_BIT   = 17;
	localparam int LOAD_TBL_BIT   = 16;
	localparam int ARB_SEL_LSB    = 17;
	localparam int CHAN_ID_LSB    = 24;
	localparam int CHAN_EN_BIT    = 31;
	localparam int SLOTS_LSB      = 16;
	localparam int TBL_OFF_LSB    = 24;
	// strap dependent reset values, then class map reset value and write mask
	localparam logic [7:0] ARB_CAP_PRESENT = 8'h19;
	localparam logic [6:0] SLOTS_PRESENT   = 7'h7F;
	localparam logic [7:0] TBL_OFF_PRESENT = 8'h08;
	localparam logic [2:0] CHAN_ID_PRESENT = 3'h1;
	localparam logic [7:0] TC_MAP_RESET    = 8'h00;
	localparam logic [7:0] TC_MAP_WMASK    = 8'hFE;
	// arbitration schemes
	typedef enum logic [2:0] {
		ARB_DEFAULT  = 3'b000,
		ARB_WRR      = 3'b011,
		ARB_TIME_WRR = 3'b100
	} arb_scheme_t;
	// interrupt event bits
	localparam int IRQ_W          = 3;
	localparam int EV_TBL_WRITE   = 0;
	localparam int EV_LOAD_DONE   = 1;
	localparam int EV_NEG_DONE    = 2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic        hsel;
		logic [11:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_t;

	typedef struct packed {
		logic        channel_enable;
		logic [2:0]  channel_identifier;
		arb_scheme_t arb_select;
		logic [7:0]  traffic_class_map;
	} chan_ctrl_t;
endpackage

// ==== src/vc_resource_regs.sv ====
`timescale 1ns/1ps
module vc_resource_regs
(
	// clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        reset_n_i,
	// register bus
	input  wire vc_resource_pkg::ahb_req_t   ahb_i,
	output logic                             hreadyout_o,
	output logic                             hresp_o,
	output logic [31:0]                      hrdata_o,
	// switch core side
	input  wire logic                        presence_strap_i,
	input  wire logic                        arb_table_write_i,
	input  wire logic                        load_done_i,
	input  wire logic                        neg_pending_i,
	input  wire logic                        autoload_valid_i,
	input  wire logic [7:0]                  autoload_map_i,
	output logic                             load_table_o,
	output vc_resource_pkg::chan_ctrl_t      chan_ctrl_o,
	// interrupt
	output logic                             irq_o
);
	import vc_resource_pkg::*;

	function automatic arb_scheme_t legal_scheme(input logic [2:0] v);
		case (v)
			ARB_WRR:      legal_scheme = ARB_WRR;
			ARB_TIME_WRR: legal_scheme = ARB_TIME_WRR;
			default:      legal_scheme = ARB_DEFAULT;
		endcase
	endfunction

	logic              strap_r;
	logic              strap_done_r;
	logic [7:0]        cap_arb_r;
	logic [6:0]        cap_slots_r;
	logic [7:0]        cap_off_r;
	logic              tbl_status_r;
	logic              load_busy_r;
	logic              neg_pending_r;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic              wr_pend_r;
	logic              rd_pend_r;
	logic [11:0]       addr_r;
	logic              load_table_r;
	chan_ctrl_t        ctrl_r;
	logic              hready_r;
	logic [31:0]       hrdata_r;
	logic              addr_ok;
	logic              wr_ctrl;
	logic              wr_irq_stat;
	logic              wr_irq_mask;
	logic [IRQ_W-1:0]  events;
	logic [31:0]       rd_val;

	assign addr_ok     = ahb_i.hsel && ahb_i.hready
		&& ahb_i.htrans == HTRANS_NONSEQ;
	assign wr_ctrl     = wr_pend_r && addr_r == CTRL1_ADDR;
	assign wr_irq_stat = wr_pend_r && addr_r == IRQ_STAT_ADDR;
	assign wr_irq_mask = wr_pend_r && addr_r == IRQ_MASK_ADDR;

	// bus phases; reads take one wait state so a write just before lands
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 12'h000;
			hready_r  <= 1'b1;
		end
		else
		begin
			wr_pend_r <= addr_ok && ahb_i.hwrite;
			rd_pend_r <= addr_ok && !ahb_i.hwrite;
			hready_r  <= !(addr_ok && !ahb_i.hwrite);
			if (addr_ok)
				addr_r <= ahb_i.haddr;
		end
	end

	// read mux; unmapped and reserved bits read zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (addr_r)
			STATUS0_ADDR:
			begin
				rd_val[TBL_STATUS_BIT] = tbl_status_r;
				rd_val[NEG_PEND_BIT]   = neg_pending_r;
			end
			CAP1_ADDR:
			begin
				rd_val[7:0]                    = cap_arb_r;
				rd_val[SLOTS_LSB+:7]           = cap_slots_r;
				rd_val[TBL_OFF_LSB+:8]         = cap_off_r;
				rd_val[14]                     = 1'b0;
			end
			CTRL1_ADDR:
			begin
				rd_val[7:0]              = ctrl_r.traffic_class_map;
				rd_val[LOAD_TBL_BIT]     = 1'b0;
				rd_val[ARB_SEL_LSB+:3]   = ctrl_r.arb_select;
				rd_val[CHAN_ID_LSB+:3]   = ctrl_r.channel_identifier;
				rd_val[CHAN_EN_BIT]      = ctrl_r.channel_enable;
			end
			IRQ_STAT_ADDR: rd_val[IRQ_W-1:0] = irq_stat_r;
			IRQ_MASK_ADDR: rd_val[IRQ_W-1:0] = irq_mask_r;
			default:       rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hrdata_r <= 32'h0000_0000;
		else if (rd_pend_r)
			hrdata_r <= rd_val;
	end

	// strap sampled while reset is held, so a strap that settles late
	// in reset still counts; no reset of its own, the pin is its source
	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
			strap_r <= presence_strap_i;
	end

	// capabilities take the sampled strap on the first edge after release
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			strap_done_r <= 1'b0;
			cap_arb_r    <= 8'h00;
			cap_slots_r  <= 7'h00;
			cap_off_r    <= 8'h00;
		end
		else if (!strap_done_r)
		begin
			strap_done_r <= 1'b1;
			cap_arb_r    <= strap_r ? ARB_CAP_PRESENT
				: 8'h00;
			cap_slots_r  <= strap_r ? SLOTS_PRESENT
				: 7'h00;
			cap_off_r    <= strap_r ? TBL_OFF_PRESENT
				: 8'h00;
		end
	end

	// control register; strap-dependent id loaded with the capabilities
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_r.traffic_class_map  <= TC_MAP_RESET;
			ctrl_r.arb_select         <= ARB_DEFAULT;
			ctrl_r.channel_identifier <= 3'h0;
			ctrl_r.channel_enable     <= 1'b0;
		end
		else if (!strap_done_r)
			ctrl_r.channel_identifier <= strap_r
				? CHAN_ID_PRESENT : 3'h0;
		else if (wr_ctrl)
		begin
			ctrl_r.traffic_class_map  <= ahb_i.hwdata[7:0]
				& TC_MAP_WMASK;
			ctrl_r.arb_select         <= legal_scheme(
				ahb_i.hwdata[ARB_SEL_LSB+:3]);
			ctrl_r.channel_identifier <= ahb_i.hwdata[CHAN_ID_LSB+:3];
			ctrl_r.channel_enable     <= ahb_i.hwdata[CHAN_EN_BIT];
		end
		else if (autoload_valid_i)
			ctrl_r.traffic_class_map  <= autoload_map_i
				& TC_MAP_WMASK;
	end

	// load trigger is a one-cycle pulse; nothing is stored for readback
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			load_table_r <= 1'b0;
		else
			load_table_r <= wr_ctrl
				&& ahb_i.hwdata[LOAD_TBL_BIT];
	end

	// table status: a fresh table write wins over a finishing load
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tbl_status_r <= 1'b0;
			load_busy_r  <= 1'b0;
		end
		else
		begin
			if (load_table_r)
				load_busy_r <= 1'b1;
			else if (load_done_i)
				load_busy_r <= 1'b0;
			if (arb_table_write_i)
				tbl_status_r <= 1'b1;
			else if (load_busy_r && load_done_i)
				tbl_status_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			neg_pending_r <= 1'b0;
		else
			neg_pending_r <= neg_pending_i;
	end

	assign events[EV_TBL_WRITE] = arb_table_write_i;
	assign events[EV_LOAD_DONE] = load_busy_r && load_done_i;
	assign events[EV_NEG_DONE]  = neg_pending_r && !neg_pending_i;

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq_o      <= 1'b0;
		end
		else
		begin
			irq_stat_r <= events | (irq_stat_r
				& ~(wr_irq_stat ? ahb_i.hwdata[IRQ_W-1:0] : '0));
			if (wr_irq_mask)
				irq_mask_r <= ahb_i.hwdata[IRQ_W-1:0];
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hresp_o <= 1'b0;
		else
			hresp_o <= 1'b0;
	end

	assign hreadyout_o  = hready_r;
	assign hrdata_o     = hrdata_r;
	assign load_table_o = load_table_r;
	assign chan_ctrl_o  = ctrl_r;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	table_set_a: assert property (
		arb_table_write_i |=> tbl_status_r)
		else $error("table write did not set status");
	table_clear_a: assert property (
		(load_busy_r && load_done_i && !arb_table_write_i)
		|=> !tbl_status_r)
		else $error("load finish did not clear status");
	neg_follow_a: assert property (
		neg_pending_i |=> neg_pending_r)
		else $error("negotiation flag not following");
	cap_strap_a: assert property (
		(!strap_done_r && strap_r)
		|=> cap_arb_r == ARB_CAP_PRESENT && cap_slots_r == SLOTS_PRESENT
		&& cap_off_r == TBL_OFF_PRESENT)
		else $error("capability not loaded from strap");
	cap_nostrap_a: assert property (
		(!strap_done_r && !strap_r)
		|=> cap_arb_r == 8'h00 && cap_slots_r == 7'h00
		&& ctrl_r.channel_identifier == 3'h0)
		else $error("capability nonzero without strap");
	map_bit0_a: assert property (
		!ctrl_r.traffic_class_map[0])
		else $error("class map bit 0 set");
	load_pulse_a: assert property (
		load_table_r |=> !load_table_r || $past(wr_ctrl))
		else $error("load pulse stretched");
	arb_legal_a: assert property (
		wr_ctrl && !(ahb_i.hwdata[ARB_SEL_LSB+:3] inside {3'b011, 3'b100})
		|=> ctrl_r.arb_select == ARB_DEFAULT)
		else $error("illegal scheme kept");
	enable_wr_a: assert property (
		wr_ctrl && strap_done_r
		|=> ctrl_r.channel_enable == $past(ahb_i.hwdata[CHAN_EN_BIT]))
		else $error("enable not written");
	read_zero_a: assert property (
		rd_pend_r && addr_r == STATUS0_ADDR
		|=> hrdata_r[15:0] == 16'h0000 && hrdata_r[31:18] == 14'h0000
		&& hreadyout_o)
		else $error("status reserved bits not zero");

	// field checks, reset values of offset, id and enable included
	neg_clear_a: assert property (
		!neg_pending_i |=> !neg_pending_r)
		else $error("negotiation flag not cleared");
	table_hold_a: assert property (
		(tbl_status_r && !(load_busy_r && load_done_i))
		|=> tbl_status_r)
		else $error("table status dropped early");
	table_idle_a: assert property (
		(!tbl_status_r && !arb_table_write_i)
		|=> !tbl_status_r)
		else $error("table status set without write");
	load_needed_a: assert property (
		(tbl_status_r && !load_busy_r && load_done_i)
		|=> tbl_status_r)
		else $error("status cleared without load trigger");
	cap_hold_a: assert property (
		strap_done_r |=> $stable(cap_arb_r) && $stable(cap_slots_r)
		&& $stable(cap_off_r))
		else $error("capability changed after reset");
	off_nostrap_a: assert property (
		(!strap_done_r && !strap_r) |=> cap_off_r == 8'h00)
		else $error("table offset nonzero without strap");
	id_strap_a: assert property (
		(!strap_done_r && strap_r)
		|=> ctrl_r.channel_identifier == CHAN_ID_PRESENT)
		else $error("channel id not loaded from strap");
	enable_reset_a: assert property (
		!strap_done_r |=> !ctrl_r.channel_enable)
		else $error("channel enabled out of reset");
	cap_read_a: assert property (
		(rd_pend_r && addr_r == CAP1_ADDR)
		|=> hrdata_r[15:8] == 8'h00 && !hrdata_r[23])
		else $error("capability reserved bits not zero");
	ctrl_read_a: assert property (
		(rd_pend_r && addr_r == CTRL1_ADDR)
		|=> !hrdata_r[LOAD_TBL_BIT] && hrdata_r[15:8] == 8'h00
		&& hrdata_r[23:20] == 4'h0 && hrdata_r[30:27] == 4'h0)
		else $error("control read shows load bit or reserved");
	map_write_a: assert property (
		wr_ctrl |=> ctrl_r.traffic_class_map
		== ($past(ahb_i.hwdata[7:0]) & TC_MAP_WMASK))
		else $error("class map write not applied");
	autoload_a: assert property (
		(autoload_valid_i && !wr_ctrl && strap_done_r)
		|=> ctrl_r.traffic_class_map
		== ($past(autoload_map_i) & TC_MAP_WMASK))
		else $error("autoloaded class map not applied");
	arb_keep_a: assert property (
		(wr_ctrl && ahb_i.hwdata[ARB_SEL_LSB+:3] inside {3'b011, 3'b100})
		|=> ctrl_r.arb_select == $past(ahb_i.hwdata[ARB_SEL_LSB+:3]))
		else $error("legal scheme not stored");
	load_trigger_a: assert property (
		(wr_ctrl && ahb_i.hwdata[LOAD_TBL_BIT]) |=> load_table_r)
		else $error("load trigger not pulsed");
	id_write_a: assert property (
		wr_ctrl |=> ctrl_r.channel_identifier
		== $past(ahb_i.hwdata[CHAN_ID_LSB+:3]))
		else $error("channel id write not applied");
	status_read_a: assert property (
		(rd_pend_r && addr_r == STATUS0_ADDR)
		|=> hrdata_r[TBL_STATUS_BIT] == $past(tbl_status_r))
		else $error("status read lost table flag");
	table_event_a: assert property (
		arb_table_write_i |=> irq_stat_r[EV_TBL_WRITE])
		else $error("table write event lost");
	neg_read_a: assert property (
		(rd_pend_r && addr_r == STATUS0_ADDR)
		|=> hrdata_r[NEG_PEND_BIT] == $past(neg_pending_r))
		else $error("status read lost negotiation flag");

	// bus timing and interrupt level; no rule of their own
	read_wait_a: assert property (
		(addr_ok && !ahb_i.hwrite) |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state not one cycle");
	write_nowait_a: assert property (
		(addr_ok && ahb_i.hwrite) |=> hreadyout_o)
		else $error("write data phase stalled");
	irq_level_a: assert property (
		|(irq_stat_r & irq_mask_r) |=> irq_o)
		else $error("unmasked event did not raise interrupt");
	irq_quiet_a: assert property (
		!(|(irq_stat_r & irq_mask_r)) |=> !irq_o)
		else $error("interrupt without unmasked event");
endmodule // vc_resource_regs

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
	import vc_resource_pkg::*;
	logic              clock_i;
	logic              reset_n_i;
	logic              strap;
	logic              tbl_wr;
	logic              ld_done;
	logic              neg;
	logic              al_valid;
	logic [7:0]        al_map;
	logic              hsel;
	logic              hwrite;
	logic [1:0]        htrans;
	logic [11:0]       haddr;
	logic [31:0]       hwdata;
	logic              hreadyout_o;
	logic              hresp_o;
	logic [31:0]       hrdata_o;
	logic              load_table_o;
	logic              irq_o;
	chan_ctrl_t        ctrl;
	ahb_req_t          ahb;
	int                err_count;
	int                checks;
	int                cyc;

	// hready is the one slave's own hreadyout
	assign ahb = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout_o};

	vc_resource_regs i_dut
	(
		.clock_i          (clock_i),
		.reset_n_i        (reset_n_i),
		.ahb_i            (ahb),
		.hreadyout_o      (hreadyout_o),
		.hresp_o          (hresp_o),
		.hrdata_o         (hrdata_o),
		.presence_strap_i (strap),
		.arb_table_write_i(tbl_wr),
		.load_done_i      (ld_done),
		.neg_pending_i    (neg),
		.autoload_valid_i (al_valid),
		.autoload_map_i   (al_map),
		.load_table_o     (load_table_o),
		.chan_ctrl_o      (ctrl),
		.irq_o            (irq_o)
	);

	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task end_sim;
		$display("errors=%0d checks=%0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// the overall timeout stands in for bounded waits on hreadyout
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			end_sim();
		end
	end

	task bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clock_i);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(v, exp);
		check({31'h0, hresp_o}, 32'h0);
	endtask

	task do_reset(input logic s);
		@(posedge clock_i);
		reset_n_i <= 1'b0;
		strap     <= s;
		repeat (12) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clock_i);
	endtask

	task t_reset_present;
		rd(STATUS0_ADDR, 32'h0000_0000);
		rd(CAP1_ADDR, 32'h087F_0019);
		rd(CTRL1_ADDR, 32'h0100_0000);
		check({17'h0, ctrl}, 32'h0000_0800);
	endtask

	task t_ctrl_write;
		wr(CTRL1_ADDR, 32'hFFFF_FFFF);
		#1 check({31'h0, load_table_o}, 32'h1);
		@(posedge clock_i);
		#1 check({31'h0, load_table_o}, 32'h0);
		check({17'h0, ctrl}, 32'h0000_78FE);
		rd(CTRL1_ADDR, 32'h8700_00FE);
		wr(CAP1_ADDR, 32'hFFFF_FFFF);
		rd(CAP1_ADDR, 32'h087F_0019);
		rd(12'h100, 32'h0000_0000);
	endtask

	task t_arb_select;
		logic [2:0] sel [4];
		logic [2:0] exp;
		sel = '{3'b000, 3'b011, 3'b100, 3'b101};
		foreach (sel[i])
		begin
			exp = (sel[i] == 3'b101) ? 3'b000 : sel[i];
			wr(CTRL1_ADDR, {12'h0, sel[i], 17'h0});
			rd(CTRL1_ADDR, {12'h0, exp, 17'h0});
		end
	endtask

	task t_autoload;
		@(posedge clock_i);
		al_map   <= 8'hFF;
		al_valid <= 1'b1;
		@(posedge clock_i);
		al_valid <= 1'b0;
		rd(CTRL1_ADDR, 32'h0000_00FE);
	endtask

	task t_status_irq;
		wr(IRQ_MASK_ADDR, 32'h7);
		@(posedge clock_i);
		tbl_wr <= 1'b1;
		@(posedge clock_i);
		tbl_wr <= 1'b0;
		rd(STATUS0_ADDR, 32'h0001_0000);
		check({31'h0, irq_o}, 32'h1);
		wr(CTRL1_ADDR, 32'h0001_0000);
		@(posedge clock_i);
		ld_done <= 1'b1;
		@(posedge clock_i);
		ld_done <= 1'b0;
		rd(STATUS0_ADDR, 32'h0000_0000);
		rd(IRQ_STAT_ADDR, 32'h3);
		wr(IRQ_STAT_ADDR, 32'h3);
		rd(IRQ_STAT_ADDR, 32'h0);
		@(posedge clock_i);
		neg <= 1'b1;
		rd(STATUS0_ADDR, 32'h0002_0000);
		@(posedge clock_i);
		neg <= 1'b0;
		rd(STATUS0_ADDR, 32'h0000_0000);
		rd(IRQ_STAT_ADDR, 32'h4);
		check({31'h0, irq_o}, 32'h1);
		wr(IRQ_MASK_ADDR, 32'h0);
		repeat (2) @(posedge clock_i);
		#1 check({31'h0, irq_o}, 32'h0);
		@(posedge clock_i);
		tbl_wr  <= 1'b1;
		@(posedge clock_i);
		tbl_wr  <= 1'b0;
		ld_done <= 1'b1;
		@(posedge clock_i);
		ld_done <= 1'b0;
		rd(STATUS0_ADDR, 32'h0001_0000);
	endtask

	task t_reset_absent;
		do_reset(1'b0);
		rd(STATUS0_ADDR, 32'h0000_0000);
		rd(CAP1_ADDR, 32'h0000_0000);
		rd(CTRL1_ADDR, 32'h0000_0000);
		check({17'h0, ctrl}, 32'h0);
	endtask

	initial
	begin
		err_count = 0;
		checks    = 0;
		cyc       = 0;
		reset_n_i = 1'b0;
		strap     = 1'b1;
		tbl_wr    = 1'b0;
		ld_done   = 1'b0;
		neg       = 1'b0;
		al_valid  = 1'b0;
		al_map    = 8'h00;
		hsel      = 1'b0;
		hwrite    = 1'b0;
		htrans    = 2'h0;
		haddr     = 12'h000;
		hwdata    = 32'h0;
		do_reset(1'b1);
		t_reset_present();
		t_ctrl_write();
		t_arb_select();
		t_autoload();
		t_status_irq();
		t_reset_absent();
		end_sim();
	end
endmodule // tb
